// file: core/sla_pkg.sv
package sla_pkg;

    // register byte addresses on the wishbone bus
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_DATA = 32'h0000_0004;

    // arbiter_control field positions
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_LOST = 5;
    localparam int CTRL_CLK_SEL = 4;
    localparam int CTRL_DONE = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_OVF = 1;
    localparam int CTRL_MSB = 0;

    // values after reset
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic CLK_SEL_RESET = 1'b0;
    localparam logic [8:0] COUNT_RESET = 9'h000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // mode select codes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEASURE = 2'h1;
    localparam logic [1:0] MODE_ARBITRATE = 2'h2;

    // counter figures
    localparam logic [8:0] COUNT_ALL_ONES = 9'h1FF;
    localparam logic [8:0] SAMPLE_AT_BUS = 9'h038;
    localparam logic [8:0] SAMPLE_AT_PRESC = 9'h008;

    // bus clock divided by this for the counter when clock select is 0
    localparam int BUS_DIV = 4;
    localparam logic [1:0] BUS_DIV_LAST = 2'(BUS_DIV - 1);

    // receive line idles high
    localparam logic RX_IDLE = 1'b1;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_M_WAIT,
        ST_M_RUN,
        ST_M_DONE,
        ST_A_WAIT,
        ST_A_RUN
    } sla_state_t;

endpackage

// file: core/sla_rx_sync.sv
// brings the receive pin into the clock domain and finds its edges
module sla_rx_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rx_pin_i,
    output logic rx_o,
    output logic fall_o,
    output logic rise_o
);
    import sla_pkg::*;

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // two-stage synchroniser, third stage only for edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= RX_IDLE;
            sync_q <= RX_IDLE;
            prev_q <= RX_IDLE;
        end
        else
        begin
            meta_q <= rx_pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges seen on the synchronised level
    assign rx_o = sync_q;
    assign fall_o = prev_q & ~sync_q;
    assign rise_o = ~prev_q & sync_q;
endmodule

// file: core/sla_tick_gen.sv
// counter clock enables: quarter of the bus clock or half the prescaler rate
module sla_tick_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clk_sel_i,
    input wire logic presc_en_i,
    output logic tick_o
);
    import sla_pkg::*;

    logic [1:0] div_q;
    logic half_q;
    logic quarter_tick;
    logic half_tick;

    // free-running dividers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_q <= 2'h0;
            half_q <= 1'b0;
        end
        else
        begin
            div_q <= (div_q == BUS_DIV_LAST) ? 2'h0 : div_q + 2'h1;
            if (presc_en_i)
            begin
                half_q <= ~half_q;
            end
        end
    end

    // one-cycle pulses at the chosen rate
    assign quarter_tick = (div_q == BUS_DIV_LAST);
    assign half_tick = presc_en_i & half_q;
    assign tick_o = clk_sel_i ? half_tick : quarter_tick;
endmodule

// file: core/sla_arbiter.sv
module sla_arbiter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    input wire logic transceiver_tx_out_i,
    input wire logic presc_en_i,
    output logic txd_o,
    output logic [1:0] mode_sel_o,
    output logic arbitration_lost_o
);
    import sla_pkg::*;

    // bus slave state
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;

    // software-visible state
    logic [1:0] mode_sel_q;
    logic [1:0] mode_sel_d;
    logic clk_sel_q;
    logic clk_sel_d;
    logic arbitration_lost_q;
    logic arbitration_lost_d;
    logic measure_done_q;
    logic measure_done_d;
    logic count_overflow_q;
    logic count_overflow_d;
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;

    // sequencing state
    sla_state_t state_q;
    sla_state_t state_d;
    logic sampled_q;
    logic sampled_d;
    logic seen_low_q;
    logic seen_low_d;
    logic tx_prev_q;

    // decoded bus terms
    logic bus_req;
    logic bus_take;
    logic hit_ctrl;
    logic hit_data;
    logic ctrl_wr;
    logic lost_clr;
    logic [1:0] wr_mode;

    // receive line and counter clock
    logic rx_lvl;
    logic rx_fall;
    logic rx_rise;
    logic tick;
    logic tx_rise;
    logic [8:0] sample_at;

    // sequencer outputs
    logic cnt_clr;
    logic count_en;
    logic done_set;
    logic lost_set;
    logic ovf_set;
    logic count_running;
    logic [7:0] ctrl_view;

    sla_rx_sync u_rx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rx_pin_i(rxd_i),
        .rx_o(rx_lvl),
        .fall_o(rx_fall),
        .rise_o(rx_rise)
    );

    sla_tick_gen u_tick_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_sel_i(clk_sel_q),
        .presc_en_i(presc_en_i),
        .tick_o(tick)
    );

    // wishbone decode; a write lands on the edge where ack is seen
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_take = bus_req & ack_q;
    assign hit_ctrl = (wb_adr_i[31:2] == ADDR_CTRL[31:2]);
    assign hit_data = (wb_adr_i[31:2] == ADDR_DATA[31:2]);
    assign ctrl_wr = bus_take & wb_we_i & hit_ctrl & wb_sel_i[0];
    assign wr_mode = wb_dat_i[CTRL_MODE_HI:CTRL_MODE_LO];
    assign lost_clr = ctrl_wr & ~wb_dat_i[CTRL_MODE_HI];

    // arbitration helpers
    assign tx_rise = transceiver_tx_out_i & ~tx_prev_q;
    assign sample_at = clk_sel_q ? SAMPLE_AT_PRESC : SAMPLE_AT_BUS;

    // status views
    assign count_running = (state_q == ST_M_RUN) | (state_q == ST_A_RUN);
    assign ovf_set = count_en & (cnt_q == COUNT_ALL_ONES);

    // control register image, count msb in bit 0
    assign ctrl_view[CTRL_MODE_HI] = mode_sel_q[1];
    assign ctrl_view[CTRL_MODE_LO] = mode_sel_q[0];
    assign ctrl_view[CTRL_LOST] = arbitration_lost_q;
    assign ctrl_view[CTRL_CLK_SEL] = clk_sel_q;
    assign ctrl_view[CTRL_DONE] = measure_done_q;
    assign ctrl_view[CTRL_RUN] = count_running;
    assign ctrl_view[CTRL_OVF] = count_overflow_q;
    assign ctrl_view[CTRL_MSB] = cnt_q[8];

    // read data chosen while the request waits for ack
    always_comb
    begin
        rdat_d = RDATA_RESET;
        if (hit_ctrl)
        begin
            rdat_d[7:0] = ctrl_view;
        end
        else if (hit_data)
        begin
            rdat_d[7:0] = cnt_q[7:0];
        end
    end

    // sequencer: mode entry, edge handling and counter steering
    always_comb
    begin
        state_d = state_q;
        cnt_clr = 1'b0;
        count_en = 1'b0;
        done_set = 1'b0;
        lost_set = 1'b0;
        sampled_d = sampled_q;
        seen_low_d = seen_low_q;
        if (ctrl_wr)
        begin
            // any control write with byte 0 selected clears the count and re-arms the mode
            cnt_clr = 1'b1;
            sampled_d = 1'b0;
            seen_low_d = 1'b0;
            case (wr_mode)
                MODE_MEASURE: state_d = ST_M_WAIT;
                MODE_ARBITRATE: state_d = ST_A_WAIT;
                default: state_d = ST_IDLE;
            endcase
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_clr = 1'b1;
                end
                ST_M_WAIT:
                begin
                    // level test also covers a line already low at enable
                    if (clk_sel_q ? ~rx_lvl : rx_fall)
                    begin
                        state_d = ST_M_RUN;
                    end
                end
                ST_M_RUN:
                begin
                    if (clk_sel_q ? rx_rise : rx_fall)
                    begin
                        state_d = ST_M_DONE;
                        done_set = 1'b1;
                    end
                    else
                    begin
                        count_en = tick;
                    end
                end
                ST_M_DONE:
                begin
                    state_d = ST_M_DONE;
                end
                ST_A_WAIT:
                begin
                    if (tx_rise)
                    begin
                        cnt_clr = 1'b1;
                        sampled_d = 1'b0;
                        seen_low_d = 1'b0;
                        state_d = ST_A_RUN;
                    end
                end
                ST_A_RUN:
                begin
                    if (tx_rise)
                    begin
                        cnt_clr = 1'b1;
                        sampled_d = 1'b0;
                        seen_low_d = 1'b0;
                    end
                    else if (~transceiver_tx_out_i & ~seen_low_q)
                    begin
                        cnt_clr = 1'b1;
                        state_d = ST_A_WAIT;
                    end
                    else
                    begin
                        count_en = tick;
                        // one static look at the line per restart
                        if (~sampled_q & (cnt_q == sample_at))
                        begin
                            sampled_d = 1'b1;
                            if (~rx_lvl)
                            begin
                                lost_set = 1'b1;
                                seen_low_d = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // next values of the software-visible bits; a set beats a clear
    always_comb
    begin
        mode_sel_d = mode_sel_q;
        clk_sel_d = clk_sel_q;
        if (ctrl_wr)
        begin
            mode_sel_d = wr_mode;
            clk_sel_d = wb_dat_i[CTRL_CLK_SEL];
        end
        arbitration_lost_d = lost_set | (arbitration_lost_q & ~lost_clr);
        measure_done_d = done_set | (measure_done_q & ~ctrl_wr);
        count_overflow_d = ovf_set | (count_overflow_q & ~ctrl_wr);
    end

    // counter, wrapping past all ones
    always_comb
    begin
        cnt_d = cnt_q;
        if (cnt_clr)
        begin
            cnt_d = COUNT_RESET;
        end
        else if (count_en)
        begin
            cnt_d = cnt_q + 9'h001;
        end
    end

    // wishbone slave: ack one cycle after the request, for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= RDATA_RESET;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q)
            begin
                rdat_q <= rdat_d;
            end
        end
    end

    // control and status flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_sel_q <= MODE_RESET;
            clk_sel_q <= CLK_SEL_RESET;
            arbitration_lost_q <= 1'b0;
            measure_done_q <= 1'b0;
            count_overflow_q <= 1'b0;
        end
        else
        begin
            mode_sel_q <= mode_sel_d;
            clk_sel_q <= clk_sel_d;
            arbitration_lost_q <= arbitration_lost_d;
            measure_done_q <= measure_done_d;
            count_overflow_q <= count_overflow_d;
        end
    end

    // counter and sequencer flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= COUNT_RESET;
            state_q <= ST_IDLE;
            sampled_q <= 1'b0;
            seen_low_q <= 1'b0;
            tx_prev_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            state_q <= state_d;
            sampled_q <= sampled_d;
            seen_low_q <= seen_low_d;
            tx_prev_q <= transceiver_tx_out_i;
        end
    end

    // transmit pin held recessive while arbitration is lost
    assign txd_o = transceiver_tx_out_i | arbitration_lost_q;

    // bus and status outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign mode_sel_o = mode_sel_q;
    assign arbitration_lost_o = arbitration_lost_q;
endmodule

// file: verification/sla_arbiter_sva.sv
module sla_arbiter_sva
    import sla_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rxd_i,
    input wire logic transceiver_tx_out_i,
    input wire logic presc_en_i,
    input wire logic txd_o,
    input wire logic [1:0] mode_sel_o,
    input wire logic arbitration_lost_o
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // control write taking effect, and the clearing kind of it
    wire logic wr_c = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
        & (wb_adr_i == ADDR_CTRL);
    wire logic clr_c = wr_c & ~wb_dat_i[CTRL_MODE_HI];

    property p_txd;
        txd_o == (transceiver_tx_out_i | arbitration_lost_o);
    endproperty
    a_txd: assert property (p_txd) else $error("transmit pin not forced");

    property p_mode;
        wr_c |=> mode_sel_o == $past(wb_dat_i[7:6]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");

    property p_clr;
        clr_c |=> !arbitration_lost_o;
    endproperty
    a_clr: assert property (p_clr) else $error("lost not cleared");

    property p_hold;
        arbitration_lost_o && !clr_c |=> arbitration_lost_o;
    endproperty
    a_hold: assert property (p_hold) else $error("lost dropped");

    property p_set;
        $rose(arbitration_lost_o) |-> mode_sel_o == MODE_ARBITRATE;
    endproperty
    a_set: assert property (p_set) else $error("lost outside arbitration");

    property p_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_one: assert property (p_one) else $error("ack too long");

    property p_hi;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");

    property p_idle;
        wb_ack_o && !wb_we_i && wb_adr_i == ADDR_DATA
            && $past(mode_sel_o) == MODE_IDLE |-> wb_dat_o[7:0] == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("idle count not zero");
endmodule

// file: verification/sla_bus_node.sv
// another node on the shared line: wired-and with a pull-up
module sla_bus_node (
    input wire logic txd_i,
    input wire logic pull_low_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // dominant low from either node, recessive high otherwise
    assign line_o = txd_i & ~pull_low_i;
endmodule

// file: verification/sla_arbiter_tb_top.sv
module sla_arbiter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sla_pkg::*;

    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rxd, txd, lost;
    logic tx = 1, presc = 0, pull = 0;
    logic [31:0] adr = 0, wdat = 0, rdat;
    logic [3:0] sel = 0;
    logic [1:0] mode;
    int n_fail = 0, tests_run = 0;

    // clock and prescaler pulse every second cycle
    always #4 clk = ~clk;
    always @(posedge clk) presc <= ~presc;

    sla_arbiter i_sla_arbiter (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd),
        .transceiver_tx_out_i(tx), .presc_en_i(presc), .txd_o(txd),
        .mode_sel_o(mode), .arbitration_lost_o(lost));
    sla_bus_node i_sla_bus_node (.txd_i(txd), .pull_low_i(pull), .line_o(rxd));

    task automatic complete_run;
        $display("fails %0d of %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cn(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int i;
        i = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1)
        begin
            n_fail++;
            complete_run;
        end
        q = rdat[7:0];
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] q;
        wb(1'b0, ADDR_DATA, 8'h00, q);
        tests_run++;
        if ((q >= lo && q <= hi) !== 1'b1)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h..%h", $time, q, lo, hi);
        end
    endtask

    task automatic t_reset;
        rdc(ADDR_CTRL, 8'h00);
        rdc(ADDR_DATA, 8'h00);
        rdc(32'h0000_0008, 8'h00);
        wr(ADDR_CTRL, 8'hC0);
        rdc(ADDR_CTRL, 8'hC0);
        rdc(ADDR_DATA, 8'h00);
    endtask

    task automatic t_meas0;
        wr(ADDR_CTRL, 8'h40);
        pull <= 1;
        cn(4);
        pull <= 0;
        rdc(ADDR_CTRL, 8'h44);
        cn(33);
        pull <= 1;
        cn(6);
        rdc(ADDR_CTRL, 8'h48);
        rng(8'h09, 8'h0B);
        pull <= 0;
    endtask

    task automatic t_meas1;
        // let the release from the previous scenario take effect first
        cn(1);
        pull <= 1;
        cn(4);
        wr(ADDR_CTRL, 8'h50);
        rdc(ADDR_CTRL, 8'h54);
        cn(33);
        pull <= 0;
        cn(6);
        rdc(ADDR_CTRL, 8'h58);
        rng(8'h08, 8'h0C);
        wr(ADDR_CTRL, 8'h10);
        rdc(ADDR_CTRL, 8'h10);
    endtask

    task automatic t_lost;
        int i;
        tx <= 0;
        wr(ADDR_CTRL, 8'h80);
        pull <= 1;
        tx <= 1;
        cn(150);
        chk({7'h00, lost}, 8'h00);
        i = 0;
        while (lost !== 1'b1 && i < 100)
        begin
            @(posedge clk);
            i++;
        end
        chk({7'h00, lost}, 8'h01);
        tx <= 0;
        cn(2);
        chk({7'h00, txd}, 8'h01);
        rdc(ADDR_CTRL, 8'hA4);
        wr(ADDR_CTRL, 8'h80);
        chk({7'h00, lost}, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        chk({7'h00, lost}, 8'h00);
        pull <= 0;
    endtask

    task automatic t_win;
        wr(ADDR_CTRL, 8'h90);
        tx <= 1;
        cn(10);
        tx <= 0;
        cn(2);
        rdc(ADDR_DATA, 8'h00);
        tx <= 1;
        cn(60);
        pull <= 1;
        cn(4);
        chk({7'h00, lost}, 8'h00);
        pull <= 0;
        wr(ADDR_CTRL, 8'h00);
    endtask

    task automatic t_ovf;
        wr(ADDR_CTRL, 8'h40);
        pull <= 1;
        cn(4);
        pull <= 0;
        cn(1100);
        rdc(ADDR_CTRL, 8'h45);
        cn(1100);
        rdc(ADDR_CTRL, 8'h46);
        wr(ADDR_CTRL, 8'h40);
        rdc(ADDR_CTRL, 8'h40);
        rdc(ADDR_DATA, 8'h00);
        wr(ADDR_CTRL, 8'h00);
    endtask

    // reset after a finished measurement must clear mode, clock select, flags and count
    task automatic t_rst;
        pull <= 1;
        cn(4);
        wr(ADDR_CTRL, 8'h50);
        cn(40);
        pull <= 0;
        cn(6);
        rdc(ADDR_CTRL, 8'h58);
        rng(8'h09, 8'h0C);
        rst <= 1;
        cn(2);
        rst <= 0;
        cn(1);
        rdc(ADDR_CTRL, 8'h00);
        rdc(ADDR_DATA, 8'h00);
    endtask

    // main sequence
    initial
    begin
        cn(10);
        rst <= 0;
        @(posedge clk);
        t_reset;
        t_meas0;
        t_meas1;
        t_lost;
        t_win;
        t_ovf;
        t_rst;
        complete_run;
    end
endmodule

bind sla_arbiter sla_arbiter_sva i_sla_arbiter_sva (.*);
